// File: dv/fuel_gauge_status_results_props.sv
// concurrent checks on the ports of the gauge status block
`timescale 1ns/1ps
module gauge_status_props #(
   parameter longint interval_cycles = 20
) (
   input wire logic                   i_clk_sys,
   input wire logic                   i_rst,
   input wire gauge_pkg::host_req_type i_host,
   input wire gauge_pkg::meas_type    i_meas,
   input wire gauge_pkg::results_type i_calc,
   input wire logic                   i_supply_sense_low,
   input wire logic                   i_bus_idle_low,
   input wire logic                   i_bus_idle_stable,
   input wire logic                   o_rvalid,
   input wire logic [7:0]             o_flags,
   input wire logic [7:0]             o_control,
   input wire logic [7:0]             o_net_address_opcode,
   input wire logic                   o_sleep_entry,
   input wire logic                   o_interval_tick,
   input wire gauge_pkg::results_type o_results
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic [31:0] gap_reg;
   logic        seen_reg;
   // cycles since the last interval tick
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         gap_reg <= '0;
         seen_reg <= 1'b0;
      end else begin
         gap_reg <= o_interval_tick ? 32'h0 : gap_reg + 32'h1;
         seen_reg <= seen_reg | o_interval_tick;
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   property p_tick_gap; o_interval_tick && seen_reg |-> gap_reg == 32'(interval_cycles - 1); endproperty
   property p_results_load; o_interval_tick |=> o_results.remaining_standby_mah == $past(i_calc.remaining_standby_mah)
      && o_results.remaining_active_percent == $past(i_calc.remaining_active_percent); endproperty
   property p_results_hold; !o_interval_tick |=> $stable(o_results); endproperty
   property p_full_clamp; o_results.full_at_temp <= gauge_pkg::full_max_value; endproperty
   property p_flags_hold; !o_interval_tick |=> $stable(o_flags[7:5]); endproperty
   property p_uv_set; i_meas.cell_potential_reading < i_meas.sleep_threshold_level |-> ##[1:2] o_flags[2]; endproperty
   property p_uv_keep; o_flags[2] && !(i_host.wr && i_host.addr == 8'h01 && !i_host.wdata[2]) |=> o_flags[2];
   endproperty
   property p_por_no_set; 1'b1 |-> !$rose(o_flags[1]); endproperty
   property p_opcode; o_control[4] |=> o_net_address_opcode == 8'h39; endproperty
   property p_ctrl_undef; (o_control & ~gauge_pkg::control_defined_mask) == 8'h00; endproperty
   property p_sleep_cause; o_sleep_entry |-> $past(o_control[6] && i_supply_sense_low && i_bus_idle_stable
      || o_control[5] && i_bus_idle_low); endproperty
   property p_sleep_learn; o_sleep_entry && !o_interval_tick |=> !o_flags[4]; endproperty
   property p_read_answer; i_host.rd |=> o_rvalid; endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("interval tick spacing wrong");
   a_results_load: assert property (p_results_load) else $error("results not loaded at tick");
   a_results_hold: assert property (p_results_hold) else $error("results moved between ticks");
   a_full_clamp: assert property (p_full_clamp) else $error("full value above one hundred percent");
   a_flags_hold: assert property (p_flags_hold) else $error("hardware flags moved between ticks");
   a_uv_set: assert property (p_uv_set) else $error("low voltage flag not set");
   a_uv_keep: assert property (p_uv_keep) else $error("low voltage flag dropped");
   a_por_no_set: assert property (p_por_no_set) else $error("power on flag rose after reset");
   a_opcode: assert property (p_opcode) else $error("net address opcode wrong");
   a_ctrl_undef: assert property (p_ctrl_undef) else $error("undefined control bits nonzero");
   a_sleep_cause: assert property (p_sleep_cause) else $error("sleep entry without cause");
   a_sleep_learn: assert property (p_sleep_learn) else $error("learn flag kept after sleep");
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   c_tick: cover property (o_interval_tick);
   c_sleep: cover property (o_sleep_entry);
   c_uv: cover property ($rose(o_flags[2]));
   c_opcode_b: cover property (o_control[4]);
endmodule
bind fuel_gauge_status_results gauge_status_props #(.interval_cycles(interval_cycles)) u_props (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_host(i_host), .i_meas(i_meas), .i_calc(i_calc),
   .i_supply_sense_low(i_supply_sense_low), .i_bus_idle_low(i_bus_idle_low), .i_bus_idle_stable(i_bus_idle_stable),
   .o_rvalid(o_rvalid), .o_flags(o_flags), .o_control(o_control), .o_net_address_opcode(o_net_address_opcode),
   .o_sleep_entry(o_sleep_entry), .o_interval_tick(o_interval_tick), .o_results(o_results));

// File: dv/gauge_host.sv
// host model: drives register reads and writes into the gauge block
`timescale 1ns/1ps
module gauge_host (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rvalid,
   input  wire logic [7:0]         i_rdata,
   output gauge_pkg::host_req_type o_host
);
   // ************************************************************
   // bus cycles
   // ************************************************************
   initial o_host = '0;
   // one-cycle write; fields inverted when idle so stale values never look valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_host = {1'b1, 1'b0, a, d};
      @(negedge i_clk_sys);
      o_host = {1'b0, 1'b0, ~a, ~d};
   endtask
   // one-cycle read; answer taken in the following cycle
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge i_clk_sys);
      o_host = {1'b0, 1'b1, a, ~o_host.wdata};
      @(negedge i_clk_sys);
      v = i_rvalid;
      d = i_rdata;
      o_host = {1'b0, 1'b0, ~a, o_host.wdata};
   endtask
   // opcode the host must issue for the net address read
   function automatic logic [7:0] net_opcode(input logic [7:0] c);
      return c[4] ? gauge_pkg::net_address_opcode_b : gauge_pkg::net_address_opcode_a;
   endfunction
endmodule

// File: dv/testbench.sv
// self-checking bench of the gauge status block with a host model
`timescale 1ns/1ps
module testbench;
   localparam longint iv = 20;
   logic                   i_clk_sys = 1'b0;
   logic                   i_rst = 1'b1;
   gauge_pkg::host_req_type host;
   gauge_pkg::meas_type    meas = {8'h80, 8'hff, 8'h40, 8'h20, 64'h0};
   gauge_pkg::results_type calc = {64'h0, 16'h0, 16'h3232};
   gauge_pkg::results_type res;
   logic [7:0] nv, rdata, flags, ctrl, opc, d, got;
   logic       rvalid, sleep, tick, ok, any;
   logic       bl = 1'b0, sl = 1'b0, bs = 1'b0, avg = 1'b0, cur = 1'b0, ccw = 1'b0;
   logic [7:0] sc [5] = '{8'h20, 8'h00, 8'h40, 8'h40, 8'h20};
   logic [3:0] sv [5] = '{4'b1001, 4'b1110, 4'b0111, 4'b0100, 4'b0110};
   logic [7:0] se [3] = '{8'h05, 8'h0c, 8'h14};
   int         mismatches = 0, cmp_count = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   fuel_gauge_status_results #(.interval_cycles(iv)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_host(host),
      .i_meas(meas), .i_calc(calc), .i_avg_update(avg), .i_current_update(cur), .i_charge_count_written(ccw),
      .i_supply_sense_low(sl), .i_bus_idle_low(bl), .i_bus_idle_stable(bs), .i_nv_control(nv), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_flags(flags), .o_control(ctrl), .o_net_address_opcode(opc), .o_sleep_entry(sleep),
      .o_interval_tick(tick), .o_results(res));
   gauge_host host_m (.i_clk_sys(i_clk_sys), .i_rvalid(rvalid), .i_rdata(rdata), .o_host(host));
   // ************************************************************
   // helpers
   // ************************************************************
   // compare and count
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // read a register and compare data and valid
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host_m.read_reg(a, got, ok);
      chk({15'h0, ok}, 16'h1);
      chk({8'h00, got}, {8'h00, e});
   endtask
   // one-cycle strobe on an update input
   task automatic pulse(ref logic s);
      @(negedge i_clk_sys) s = 1'b1;
      @(negedge i_clk_sys) s = 1'b0;
   endtask
   task automatic wait_iv(input int n);
      repeat (n * iv + 3) @(negedge i_clk_sys);
   endtask
   function automatic logic [15:0] clamp(input logic [15:0] v);
      return (v > gauge_pkg::full_max_value) ? gauge_pkg::full_max_value : v;
   endfunction
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      void'($urandom(32'hf1bd9fba));
      nv = 8'($urandom);
      repeat (3) @(negedge i_clk_sys);
      i_rst = 1'b0;
      repeat (3) @(negedge i_clk_sys);
      chk({8'h00, ctrl}, {8'h00, nv & gauge_pkg::control_defined_mask});
      rd(8'h01, 8'h02);
      rd(8'h02, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 6; k++) begin
         d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
         host_m.write_reg(8'h60, d);
         rd(8'h60, d & gauge_pkg::control_defined_mask);
         chk({8'h00, opc}, {8'h00, host_m.net_opcode(d)});
      end
      $display("test control done");
      wait_iv(2);
      host_m.write_reg(8'h01, 8'hff);
      rd(8'h01, 8'h02);
      host_m.write_reg(8'h01, 8'h00);
      rd(8'h01, 8'h00);
      calc.remaining_active_percent = 8'h03;
      wait_iv(2);
      meas.cell_potential_reading = 8'h10;
      wait_iv(1);
      rd(8'h01, 8'h44);
      host_m.write_reg(8'h01, 8'h00);
      rd(8'h01, 8'h44);
      meas.cell_potential_reading = 8'h80;
      calc.remaining_active_percent = 8'h32;
      host_m.write_reg(8'h01, 8'h00);
      wait_iv(2);
      rd(8'h01, 8'h00);
      for (int k = 0; k < 3; k++) begin
         calc.remaining_standby_percent = se[k];
         wait_iv(2);
         rd(8'h01, (k < 2) ? 8'h20 : 8'h00);
      end
      // charge done over two qualifying average updates
      meas.charge_voltage_threshold = 8'h70;
      meas.average_current = 16'h0005;
      meas.min_charge_current = 8'h10;
      pulse(avg);
      pulse(avg);
      wait_iv(1);
      rd(8'h01, 8'h80);
      meas.charge_voltage_threshold = 8'hff;
      wait_iv(1);
      rd(8'h01, 8'h00);
      // learn on a qualified falling crossing, cleared by a charge count write
      meas.accumulated_charge = 16'h0100;
      meas.active_empty_current = 8'h40;
      meas.current_reading = 16'hff00;
      pulse(cur);
      pulse(cur);
      meas.cell_potential_reading = 8'h10;
      wait_iv(1);
      rd(8'h01, 8'h54);
      pulse(ccw);
      rd(8'h01, 8'h44);
      meas = {8'h80, 8'hff, 8'h40, 8'h20, 64'h0};
      host_m.write_reg(8'h01, 8'h00);
      wait_iv(2);
      rd(8'h01, 8'h00);
      $display("test flags done");
      for (int k = 0; k < 3; k++) begin
         calc = {(k == 0) ? 16'hffff : 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
                 16'($urandom)};
         wait_iv(1);
         chk(res.full_at_temp, clamp(calc.full_at_temp));
         chk(res.remaining_active_mah, calc.remaining_active_mah);
         chk(res.active_empty_at_temp, {3'h0, calc.active_empty_at_temp[12:0]});
         chk(res.standby_empty_at_temp, {3'h0, calc.standby_empty_at_temp[12:0]});
         chk({res.remaining_active_percent, res.remaining_standby_percent}, calc[15:0]);
      end
      $display("test results done");
      for (int k = 0; k < 5; k++) begin
         host_m.write_reg(8'h60, sc[k]);
         {bl, sl, bs} = sv[k][3:1];
         any = 1'b0;
         repeat (6) @(negedge i_clk_sys) any = any | sleep;
         chk({15'h0, any}, {15'h0, sv[k][0]});
         {bl, sl, bs} = 3'b000;
         repeat (3) @(negedge i_clk_sys);
      end
      $display("test sleep done");
      give_verdict;
   end
   // cut a hang short
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      mismatches++;
      give_verdict;
   end
endmodule

// File: verilog/fuel_gauge_status_results.sv
// status flags, control shadow and result timing of the fuel gauge
//
// Contract
// [RULE_01] - recompute all seven results once every 3.5 second interval
// [RULE_02] - full at temperature, 15 bits, lsb 2^-14, clamped to 100 percent
// [RULE_03] - active empty at temperature, 13 bits, lsb 2^-14
// [RULE_04] - standby empty at temperature, 13 bits, lsb 2^-14
// [RULE_05] - remaining active and standby capacity, 16 bits mAh each
// [RULE_06] - remaining active and standby capacity, 8 bits percent each
// [RULE_07] - charge done sets on voltage and current over two averages, clears below 90
// [RULE_08] - active empty sets below voltage threshold, clears above 5 percent
// [RULE_09] - standby empty sets below 10 percent, clears above 15 percent
// [RULE_10] - learn sets on falling voltage crossing with heavy discharge
// [RULE_11] - learn clears on full, charge, charge count write, sleep, empty count; code clears on light discharge instead of charge
// [RULE_12] - host writes cannot change the four hardware flags
// [RULE_13] - low voltage flag sets below sleep level, host clears it
// [RULE_14] - power on flag sets at power up, host clears it
// [RULE_15] - control register loads from nonvolatile copy at power up
// [RULE_16] - host reads and writes all defined control bits
// [RULE_17] - bit 6 allows sleep on low supply with steady bus
// [RULE_18] - bit 5 allows sleep on bus held low
// [RULE_19] - bit 4 selects net address opcode 33h or 39h
// [RULE_20] - two previous currents must be heavy discharge before crossing
// [RULE_21] - results and flags change together at interval end; code clears learn and sets low voltage in any cycle
`timescale 1ns/1ps
module fuel_gauge_status_results #(
   parameter longint interval_cycles = gauge_pkg::interval_cycles
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst,
   input  wire gauge_pkg::host_req_type i_host,
   input  wire gauge_pkg::meas_type    i_meas,
   input  wire gauge_pkg::results_type i_calc,
   input  wire logic                   i_avg_update,
   input  wire logic                   i_current_update,
   input  wire logic                   i_charge_count_written,
   input  wire logic                   i_supply_sense_low,
   input  wire logic                   i_bus_idle_low,
   input  wire logic                   i_bus_idle_stable,
   input  wire logic [7:0]             i_nv_control,
   output logic [7:0]                  o_rdata,
   output logic                        o_rvalid,
   output logic [7:0]                  o_flags,
   output logic [7:0]                  o_control,
   output logic [7:0]                  o_net_address_opcode,
   output logic                        o_sleep_entry,
   output logic                        o_interval_tick,
   output gauge_pkg::results_type      o_results
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [31:0] timer;
      logic        tick;
      logic        started;
      logic [7:0]  flags;
      logic [7:0]  control;
      logic [7:0]  rdata;
      logic        rvalid;
      logic [7:0]  opcode;
      logic        sleep;
      logic [1:0]  heavy_hist;
      logic        v_above_ae;
      logic        below_ae_seen;
      logic        chg_window;
      logic [1:0]  chg_count;
      logic        ae_pending;
   } state_type;

   state_type state_reg;
   state_type state_next;
   gauge_pkg::results_type calc_clamped;
   gauge_pkg::results_type stored;
   logic [7:0] sr_flags;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic is_heavy_discharge(input logic [15:0] cur, input logic [7:0] thr);
      logic [15:0] mag;
      mag = 16'h0000 - cur;
      return cur[15] && (mag > {8'h00, thr});
   endfunction

   // clamp full value and narrow the empty fields
   always_comb begin
      calc_clamped = i_calc;
      if (i_calc.full_at_temp > gauge_pkg::full_max_value) begin
         calc_clamped.full_at_temp = gauge_pkg::full_max_value; // [RULE_02]
      end
      calc_clamped.full_at_temp[15] = 1'b0; // [RULE_02]
      calc_clamped.active_empty_at_temp[15:13] = 3'h0; // [RULE_03]
      calc_clamped.standby_empty_at_temp[15:13] = 3'h0; // [RULE_04]
   end

   // results register, loaded on interval tick
   result_store u_store (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_load    (state_reg.tick), // [RULE_01] [RULE_05] [RULE_06] [RULE_21]
      .i_data    (calc_clamped),
      .o_data    (stored)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic heavy_now;
      logic v_below_ae;
      logic v_above_chg;
      logic chg_cur_ok;
      logic learn_set;
      logic learn_clr;
      logic [7:0] f;
      heavy_now   = 1'b0;
      v_below_ae  = 1'b0;
      v_above_chg = 1'b0;
      chg_cur_ok  = 1'b0;
      learn_set   = 1'b0;
      learn_clr   = 1'b0;
      f           = 8'h00;
      state_next  = state_reg;
      state_next.tick   = 1'b0;
      state_next.rvalid = 1'b0;
      state_next.sleep  = 1'b0;

      // first cycle after reset: take nonvolatile control copy
      if (!state_reg.started) begin
         state_next.started = 1'b1;
         state_next.control = i_nv_control & gauge_pkg::control_defined_mask; // [RULE_15]
      end

      // interval timer
      if (state_reg.timer >= 32'(interval_cycles - 1)) begin
         state_next.timer = 32'h0000_0000;
         state_next.tick  = 1'b1; // [RULE_01]
      end else begin
         state_next.timer = state_reg.timer + 32'h0000_0001;
      end

      v_below_ae  = i_meas.cell_potential_reading < i_meas.active_empty_voltage;
      v_above_chg = i_meas.cell_potential_reading > i_meas.charge_voltage_threshold;
      chg_cur_ok  = !i_meas.average_current[15] && (i_meas.average_current != 16'h0000)
                    && (i_meas.average_current < {8'h00, i_meas.min_charge_current});

      // discharge history of the two preceding current readings
      heavy_now = is_heavy_discharge(i_meas.current_reading, i_meas.active_empty_current);
      if (i_current_update) begin
         state_next.heavy_hist = {state_reg.heavy_hist[0], heavy_now}; // [RULE_20]
      end

      // falling crossing of the active empty voltage
      state_next.v_above_ae = !v_below_ae;
      if (state_reg.v_above_ae && v_below_ae && (&state_reg.heavy_hist)) begin
         state_next.ae_pending = 1'b1; // [RULE_10] [RULE_20]
      end
      if (v_below_ae) begin
         state_next.below_ae_seen = 1'b1;
      end

      // full detect window over average updates
      if (!v_above_chg) begin
         state_next.chg_window = 1'b0; // [RULE_07]
         state_next.chg_count  = 2'h0;
      end else if (i_avg_update) begin
         if (chg_cur_ok) begin
            state_next.chg_window = 1'b1;
            if (state_reg.chg_window && state_reg.chg_count != 2'h2) begin
               state_next.chg_count = state_reg.chg_count + 2'h1; // [RULE_07]
            end
         end else begin
            state_next.chg_window = 1'b0;
            state_next.chg_count  = 2'h0;
         end
      end

      // sleep entry conditions
      if ((state_reg.control[gauge_pkg::uv_sleep_bit] && i_supply_sense_low && i_bus_idle_stable) // [RULE_17]
          || (state_reg.control[gauge_pkg::bus_sleep_bit] && i_bus_idle_low)) begin // [RULE_18]
         state_next.sleep = 1'b1;
      end

      // opcode select
      state_next.opcode = state_reg.control[gauge_pkg::opcode_sel_bit] ?
                          gauge_pkg::net_address_opcode_b : gauge_pkg::net_address_opcode_a; // [RULE_19]

      // host access, hardware bits ignore writes
      f = state_reg.flags;
      if (i_host.wr && i_host.addr == gauge_pkg::gauge_flags_addr) begin
         f = (f & ~gauge_pkg::flags_host_clear_mask)
             | (f & i_host.wdata & gauge_pkg::flags_host_clear_mask); // [RULE_12] [RULE_13] [RULE_14]
      end
      if (i_host.wr && i_host.addr == gauge_pkg::power_and_opcode_control_addr) begin
         state_next.control = i_host.wdata & gauge_pkg::control_defined_mask; // [RULE_16]
      end

      // low voltage flag, set wins over host clear
      if (i_meas.cell_potential_reading < i_meas.sleep_threshold_level) begin
         f[gauge_pkg::low_voltage_bit] = 1'b1; // [RULE_13]
      end

      // hardware flags change on interval tick
      if (state_reg.tick) begin
         if (state_reg.chg_count != 2'h0) begin
            f[gauge_pkg::charge_done_bit] = 1'b1; // [RULE_07] [RULE_21]
         end else if (stored.remaining_active_percent < gauge_pkg::charge_clear_pct) begin
            f[gauge_pkg::charge_done_bit] = 1'b0; // [RULE_07]
         end
         if (v_below_ae) begin
            f[gauge_pkg::active_empty_bit] = 1'b1; // [RULE_08]
         end else if (stored.remaining_active_percent > gauge_pkg::active_clear_pct) begin
            f[gauge_pkg::active_empty_bit] = 1'b0; // [RULE_08]
         end
         if (stored.remaining_standby_percent < gauge_pkg::standby_set_pct) begin
            f[gauge_pkg::standby_empty_bit] = 1'b1; // [RULE_09]
         end else if (stored.remaining_standby_percent > gauge_pkg::standby_clear_pct) begin
            f[gauge_pkg::standby_empty_bit] = 1'b0; // [RULE_09]
         end
         learn_set = state_reg.ae_pending;
         state_next.ae_pending = 1'b0;
      end

      // learn flag clear terms act at once
      learn_clr = f[gauge_pkg::charge_done_bit] || i_meas.current_reading[15] && !heavy_now
                  || i_charge_count_written || state_reg.sleep
                  || (state_reg.below_ae_seen && i_meas.accumulated_charge == 16'h0000); // [RULE_11]
      if (learn_set) begin
         f[gauge_pkg::learn_bit] = 1'b1; // [RULE_10]
      end else if (learn_clr) begin
         f[gauge_pkg::learn_bit] = 1'b0; // [RULE_11]
      end
      if (learn_clr && i_meas.accumulated_charge == 16'h0000) begin
         state_next.below_ae_seen = 1'b0;
      end
      f[3] = 1'b0;
      f[0] = 1'b0;
      state_next.flags = f;

      // read data
      if (i_host.rd) begin
         state_next.rvalid = 1'b1;
         if (i_host.addr == gauge_pkg::gauge_flags_addr) begin
            state_next.rdata = state_reg.flags;
         end else if (i_host.addr == gauge_pkg::power_and_opcode_control_addr) begin
            state_next.rdata = state_reg.control; // [RULE_16]
         end else begin
            state_next.rdata = 8'h00;
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg         <= '0;
         state_reg.flags   <= gauge_pkg::flags_reset_value; // [RULE_14]
         state_reg.control <= gauge_pkg::control_reset_value;
         state_reg.opcode  <= gauge_pkg::net_address_opcode_a;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sr_flags             = state_reg.flags;
   assign o_flags              = sr_flags;
   assign o_rdata              = state_reg.rdata;
   assign o_rvalid             = state_reg.rvalid;
   assign o_control            = state_reg.control;
   assign o_net_address_opcode = state_reg.opcode;
   assign o_sleep_entry        = state_reg.sleep;
   assign o_interval_tick      = state_reg.tick;
   assign o_results            = stored;

endmodule

// File: verilog/gauge_pkg.sv
// package with offsets, field positions, reset values and time constants of the gauge status block
package gauge_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] gauge_flags_addr              = 8'h01;
   localparam logic [7:0] power_and_opcode_control_addr = 8'h60;

   // ************************************************************
   // flag and control bit positions
   // ************************************************************
   localparam int charge_done_bit   = 7;
   localparam int active_empty_bit  = 6;
   localparam int standby_empty_bit = 5;
   localparam int learn_bit         = 4;
   localparam int low_voltage_bit   = 2;
   localparam int power_on_bit      = 1;
   localparam int uv_sleep_bit      = 6;
   localparam int bus_sleep_bit     = 5;
   localparam int opcode_sel_bit    = 4;

   localparam logic [7:0] flags_host_clear_mask = 8'h06;
   localparam logic [7:0] control_defined_mask  = 8'h70;
   localparam logic [7:0] flags_reset_value     = 8'h02;
   localparam logic [7:0] control_reset_value   = 8'h00;

   // ************************************************************
   // opcodes, thresholds in percent and full clamp value in units of 2^-14
   // ************************************************************
   localparam logic [7:0] net_address_opcode_a = 8'h33;
   localparam logic [7:0] net_address_opcode_b = 8'h39;
   localparam logic [7:0] charge_clear_pct     = 8'h5a;
   localparam logic [7:0] active_clear_pct     = 8'h05;
   localparam logic [7:0] standby_set_pct      = 8'h0a;
   localparam logic [7:0] standby_clear_pct    = 8'h0f;
   localparam logic [15:0] full_max_value      = 16'h4000;

   // ************************************************************
   // timing
   // ************************************************************
   localparam longint clk_hz          = 125000000;
   localparam longint interval_ms     = 3500;
   localparam longint interval_cycles = (interval_ms * clk_hz) / 1000;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [15:0] full_at_temp;
      logic [15:0] active_empty_at_temp;
      logic [15:0] standby_empty_at_temp;
      logic [15:0] remaining_active_mah;
      logic [15:0] remaining_standby_mah;
      logic [7:0]  remaining_active_percent;
      logic [7:0]  remaining_standby_percent;
   } results_type;

   typedef struct packed {
      logic [7:0]  cell_potential_reading;
      logic [7:0]  charge_voltage_threshold;
      logic [7:0]  active_empty_voltage;
      logic [7:0]  sleep_threshold_level;
      logic [15:0] average_current;
      logic [15:0] current_reading;
      logic [7:0]  min_charge_current;
      logic [7:0]  active_empty_current;
      logic [15:0] accumulated_charge;
   } meas_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } host_req_type;

endpackage

// File: verilog/result_store.sv
// result holding register: takes the computed values at interval end
`timescale 1ns/1ps
module result_store (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_load,
   input  wire gauge_pkg::results_type i_data,
   output gauge_pkg::results_type     o_data
);

   gauge_pkg::results_type data_reg;

   // hold results, update all words at once
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         data_reg <= '0;
      end else if (i_load) begin
         data_reg <= i_data;
      end
   end

   assign o_data = data_reg;

endmodule
